// ===== sfcs_sched.sv
// sfcs_sched: opcode decode and admission control for a serial flash
// with two page buffers.
// assumes: an array engine takes cmd_start_q with its code and raises
// op_done for one cycle when a self-timed phase ends.
`timescale 1ns/1ps
module sfcs_sched
  import sfcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic op_done,
  output sfcs_cmd_e cmd_q,
  output sfcs_grp_e grp_q,
  output logic buf2_q,
  output logic cmd_start_q,
  output logic reject_q,
  output logic sw_reset_q,
  output logic busy_q,
  output logic suspended_q,
  output logic power_down_q
);

  // ==========================================================
  // decode helpers

  // single-byte decode; the buffer number comes from is_buf2
  function automatic sfcs_cmd_e dec1(input logic [7:0] op);
    sfcs_cmd_e c;
    c = SFCS_C_NONE;
    unique case (op)
      OP_PAGE_RD, OP_OLD_PAGE: c = SFCS_C_PAGE_RD;
      OP_ARR_LP, OP_ARR_LF, OP_ARR_HF, OP_ARR_HF2, OP_ARR_OLD,
      OP_OLD_ARR: c = SFCS_C_ARRAY_RD;
      OP_B1_RD_LF, OP_B2_RD_LF, OP_B1_RD_HF, OP_B2_RD_HF,
      OP_OLD_B1_RD, OP_OLD_B2_RD: c = SFCS_C_BUF_RD;
      OP_B1_WR, OP_B2_WR: c = SFCS_C_BUF_WR;
      OP_B1_PROG_E, OP_B2_PROG_E: c = SFCS_C_BUF_PROG_E;
      OP_B1_PROG, OP_B2_PROG: c = SFCS_C_BUF_PROG;
      OP_B1_THRU_E, OP_B2_THRU_E: c = SFCS_C_THRU_E;
      OP_B1_THRU: c = SFCS_C_THRU;
      OP_PAGE_ER: c = SFCS_C_PAGE_ER;
      OP_BLOCK_ER: c = SFCS_C_BLOCK_ER;
      OP_SECT_ER: c = SFCS_C_SECT_ER;
      OP_SUSPEND: c = SFCS_C_SUSPEND;
      OP_RESUME: c = SFCS_C_RESUME;
      OP_B1_RMW, OP_B2_RMW: c = SFCS_C_RMW;
      OP_B1_XFER, OP_B2_XFER: c = SFCS_C_XFER;
      OP_B1_CMP, OP_B2_CMP: c = SFCS_C_CMP;
      OP_PROT_RD: c = SFCS_C_PROT_RD;
      OP_LOCK_RD: c = SFCS_C_LOCK_RD;
      OP_SEC_RD: c = SFCS_C_SEC_RD;
      OP_DPD: c = SFCS_C_DPD;
      OP_WAKE: c = SFCS_C_WAKE;
      OP_UDPD: c = SFCS_C_UDPD;
      OP_STATUS, OP_OLD_STAT: c = SFCS_C_STATUS;
      OP_ID: c = SFCS_C_ID;
      // first bytes of four-byte sequences
      SQ_CHIP_0, SQ_PROT_0, SQ_FRZ_0, SQ_SEC_0, SQ_RST_0: c = SFCS_C_SEQ;
      default: c = SFCS_C_NONE;
    endcase
    return c;
  endfunction

  // second buffer selected by this opcode
  function automatic logic is_buf2(input logic [7:0] op);
    return op == OP_B2_RD_LF || op == OP_B2_RD_HF || op == OP_OLD_B2_RD ||
      op == OP_B2_WR || op == OP_B2_PROG_E || op == OP_B2_PROG ||
      op == OP_B2_THRU_E || op == OP_B2_RMW || op == OP_B2_XFER ||
      op == OP_B2_CMP;
  endfunction

  // four-byte sequence decode
  function automatic sfcs_cmd_e dec4(input logic [7:0] b0,
      input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
    sfcs_cmd_e c;
    c = SFCS_C_NONE;
    if (b0 == SQ_CHIP_0 && b1 == SQ_CHIP_1 && b2 == SQ_CHIP_2 &&
        b3 == SQ_CHIP_3) begin
      c = SFCS_C_CHIP_ER;
    end else if (b0 == SQ_PROT_0 && b1 == SQ_PROT_1 &&
        b2 == SQ_PROT_2) begin
      unique case (b3)
        SQ_P_EN: c = SFCS_C_PROT_EN;
        SQ_P_DIS: c = SFCS_C_PROT_DIS;
        SQ_P_ERASE: c = SFCS_C_PROT_ER;
        SQ_P_PROG: c = SFCS_C_PROT_PROG;
        SQ_P_LOCK: c = SFCS_C_LOCKDOWN;
        default: c = SFCS_C_NONE;
      endcase
    end else if (b0 == SQ_PROT_0 && b1 == SQ_PROT_1 &&
        b2 == SQ_CFG_2) begin
      if (b3 == SQ_CFG_BIN) begin
        c = SFCS_C_CFG_BIN;
      end else if (b3 == SQ_CFG_STD) begin
        c = SFCS_C_CFG_STD;
      end
    end else if (b0 == SQ_FRZ_0 && b1 == SQ_FRZ_1 && b2 == SQ_FRZ_2 &&
        b3 == SQ_FRZ_3) begin
      c = SFCS_C_FREEZE;
    end else if (b0 == SQ_SEC_0 && b1 == SQ_ZERO && b2 == SQ_ZERO &&
        b3 == SQ_ZERO) begin
      c = SFCS_C_SEC_PROG;
    end else if (b0 == SQ_RST_0 && b1 == SQ_ZERO && b2 == SQ_ZERO &&
        b3 == SQ_ZERO) begin
      c = SFCS_C_SW_RESET;
    end
    return c;
  endfunction

  // group of a command
  function automatic sfcs_grp_e grp_of(input sfcs_cmd_e c);
    sfcs_grp_e g;
    g = SFCS_G_MISC;
    unique case (c)
      SFCS_C_PAGE_RD, SFCS_C_ARRAY_RD, SFCS_C_PROT_RD, SFCS_C_LOCK_RD,
      SFCS_C_SEC_RD, SFCS_C_BUF_RD: g = SFCS_G_A;
      SFCS_C_PAGE_ER, SFCS_C_BLOCK_ER, SFCS_C_SECT_ER, SFCS_C_CHIP_ER,
      SFCS_C_XFER, SFCS_C_CMP, SFCS_C_BUF_PROG_E, SFCS_C_BUF_PROG,
      SFCS_C_THRU_E, SFCS_C_THRU, SFCS_C_RMW: g = SFCS_G_B;
      SFCS_C_BUF_WR, SFCS_C_STATUS, SFCS_C_ID: g = SFCS_G_C;
      SFCS_C_PROT_ER, SFCS_C_PROT_PROG, SFCS_C_LOCKDOWN, SFCS_C_SEC_PROG,
      SFCS_C_CFG_BIN, SFCS_C_CFG_STD, SFCS_C_FREEZE,
      SFCS_C_PROT_EN, SFCS_C_PROT_DIS: g = SFCS_G_D;
      SFCS_C_NONE, SFCS_C_SEQ: g = SFCS_G_NONE;
      default: g = SFCS_G_MISC;
    endcase
    return g;
  endfunction

  // transfer, compare and rewrite cannot be suspended
  function automatic logic can_susp(input sfcs_cmd_e c);
    return grp_of(c) == SFCS_G_B && c != SFCS_C_XFER &&
      c != SFCS_C_CMP && c != SFCS_C_RMW;
  endfunction

  // erases hold no buffer, so both stay open to buffer writes
  function automatic logic uses_buf(input sfcs_cmd_e c);
    return grp_of(c) == SFCS_G_B && !(c inside {SFCS_C_PAGE_ER,
      SFCS_C_BLOCK_ER, SFCS_C_SECT_ER, SFCS_C_CHIP_ER});
  endfunction

  // admission check against the scheduler state
  function automatic logic allowed(input sfcs_state_e st,
      input logic pd, input sfcs_cmd_e c, input logic b2,
      input logic op_b2, input logic op_buf, input logic susp_ok);
    logic ok;
    sfcs_grp_e g;
    g = grp_of(c);
    ok = 1'b0;
    if (pd) begin
      ok = (c == SFCS_C_WAKE);
    end else begin
      unique case (st)
        SFCS_S_IDLE:
          ok = g != SFCS_G_NONE && c != SFCS_C_SUSPEND &&
            c != SFCS_C_RESUME && c != SFCS_C_WAKE;
        // group C runs beside the self-timed phase
        // the buffer in use is off limits
        SFCS_S_B_BUSY:
          ok = (g == SFCS_G_C &&
            !(c == SFCS_C_BUF_WR && op_buf && b2 == op_b2)) ||
            (c == SFCS_C_SUSPEND && susp_ok) || c == SFCS_C_SW_RESET;
        SFCS_S_B_SUSP:
          ok = g == SFCS_G_A || g == SFCS_G_C || c == SFCS_C_RESUME ||
            c == SFCS_C_SW_RESET;
        SFCS_S_D_BUSY:
          ok = (c == SFCS_C_STATUS);
      endcase
    end
    return ok;
  endfunction

  // ==========================================================
  // byte receiver
  logic [SFCS_BYTE_W-1:0] rx_byte;
  logic rx_stb;
  logic rx_end;
  logic rx_aligned;

  sfcs_byte_rx u_rx (
    .clk(clk),
    .reset_n(reset_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .si(si),
    .byte_q(rx_byte),
    .byte_stb_q(rx_stb),
    .frame_end_q(rx_end),
    .aligned_q(rx_aligned)
  );

  // ==========================================================
  // frame and scheduler state
  sfcs_state_e st_q, st_d; // scheduler state
  logic op_b2_q, op_b2_d; // buffer held by the running operation
  logic op_buf_q, op_buf_d; // running operation holds a buffer at all
  logic susp_ok_q, susp_ok_d; // running operation may be suspended
  logic pd_q, pd_d; // power-down level
  sfcs_cmd_e fcmd_q, fcmd_d; // first-byte decode of this frame
  logic fb2_q, fb2_d; // first byte picks buffer 2
  logic [SFCS_CNT_W-1:0] nb_q, nb_d; // bytes seen, saturating
  logic [SFCS_BYTE_W-1:0] hold_q [SFCS_SEQ_LEN];
  logic [SFCS_BYTE_W-1:0] hold_d [SFCS_SEQ_LEN];
  sfcs_cmd_e cmd_d;
  sfcs_grp_e grp_d;
  logic buf2_d, start_d, rej_d, swr_d;
  sfcs_cmd_e c4;

  // next-state for frame capture, admission and operation tracking
  always_comb begin
    st_d = st_q;
    op_b2_d = op_b2_q;
    op_buf_d = op_buf_q;
    susp_ok_d = susp_ok_q;
    pd_d = pd_q;
    fcmd_d = fcmd_q;
    fb2_d = fb2_q;
    nb_d = nb_q;
    hold_d = hold_q;
    cmd_d = cmd_q;
    grp_d = grp_q;
    buf2_d = buf2_q;
    start_d = 1'b0;
    rej_d = 1'b0;
    swr_d = 1'b0;
    c4 = dec4(hold_q[0], hold_q[1], hold_q[2], hold_q[3]);
    // engine finished a self-timed phase; a suspended one cannot finish
    if (op_done && (st_q == SFCS_S_B_BUSY || st_q == SFCS_S_D_BUSY)) begin
      st_d = SFCS_S_IDLE;
    end
    if (rx_stb) begin
      // keep the first bytes for sequence decode; extras are ignored
      if (nb_q < SFCS_SEQ_LEN) begin
        hold_d[nb_q[1:0]] = rx_byte;
        nb_d = nb_q + 3'h1;
      end
      if (nb_q == SFCS_ZERO3) begin
        fcmd_d = dec1(rx_byte);
        fb2_d = is_buf2(rx_byte);
        // streaming reads and group C start on the opcode byte
        if (grp_of(dec1(rx_byte)) == SFCS_G_A ||
            grp_of(dec1(rx_byte)) == SFCS_G_C) begin
          // refused opcodes leave the operation alone
          if (allowed(st_q, pd_q, dec1(rx_byte), is_buf2(rx_byte),
              op_b2_q, op_buf_q, susp_ok_q)) begin
            cmd_d = dec1(rx_byte);
            grp_d = grp_of(dec1(rx_byte));
            buf2_d = is_buf2(rx_byte);
            start_d = 1'b1;
          end else begin
            rej_d = 1'b1;
          end
        end
      end
    end
    if (rx_end) begin
      nb_d = SFCS_ZERO3;
      // a ragged release after a whole byte, or a short sequence, launches nothing and is refused
      if (!rx_aligned || nb_q == SFCS_ZERO3) begin
        rej_d = (nb_q != SFCS_ZERO3);
      end else if (fcmd_q == SFCS_C_SEQ) begin
        if (nb_q == SFCS_SEQ_LEN &&
            allowed(st_q, pd_q, c4, 1'b0, op_b2_q, op_buf_q,
              susp_ok_q)) begin
          cmd_d = c4;
          grp_d = grp_of(c4);
          buf2_d = 1'b0;
          start_d = 1'b1;
          if (c4 == SFCS_C_SW_RESET) begin
            // reset abandons a running group B or a suspended operation; it is refused during a group D phase
            st_d = SFCS_S_IDLE;
            swr_d = 1'b1;
          end else if (grp_of(c4) == SFCS_G_B) begin
            st_d = SFCS_S_B_BUSY;
            susp_ok_d = can_susp(c4);
            op_buf_d = uses_buf(c4);
          end else begin
            st_d = SFCS_S_D_BUSY;
          end
        end else begin
          rej_d = 1'b1;
        end
      end else if (grp_of(fcmd_q) == SFCS_G_B ||
          grp_of(fcmd_q) == SFCS_G_MISC) begin
        // self-timed and control commands launch at release
        if (allowed(st_q, pd_q, fcmd_q, fb2_q, op_b2_q, op_buf_q,
            susp_ok_q)) begin
          cmd_d = fcmd_q;
          grp_d = grp_of(fcmd_q);
          buf2_d = fb2_q;
          start_d = 1'b1;
          unique case (fcmd_q)
            SFCS_C_SUSPEND: st_d = SFCS_S_B_SUSP;
            SFCS_C_RESUME: st_d = SFCS_S_B_BUSY;
            SFCS_C_DPD, SFCS_C_UDPD: pd_d = 1'b1;
            SFCS_C_WAKE: pd_d = 1'b0;
            default: begin
              st_d = SFCS_S_B_BUSY;
              op_b2_d = fb2_q;
              susp_ok_d = can_susp(fcmd_q);
              op_buf_d = uses_buf(fcmd_q);
            end
          endcase
        end else begin
          rej_d = 1'b1;
        end
      end else if (fcmd_q == SFCS_C_NONE) begin
        rej_d = 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= SFCS_S_IDLE;
      op_b2_q <= 1'b0;
      op_buf_q <= 1'b0;
      susp_ok_q <= 1'b0;
      pd_q <= 1'b0;
      fcmd_q <= SFCS_C_NONE;
      fb2_q <= 1'b0;
      nb_q <= '0;
      hold_q <= '{default: '0};
      cmd_q <= SFCS_C_NONE;
      grp_q <= SFCS_G_NONE;
      buf2_q <= 1'b0;
      cmd_start_q <= 1'b0;
      reject_q <= 1'b0;
      sw_reset_q <= 1'b0;
      busy_q <= 1'b0;
      suspended_q <= 1'b0;
      power_down_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_b2_q <= op_b2_d;
      op_buf_q <= op_buf_d;
      susp_ok_q <= susp_ok_d;
      pd_q <= pd_d;
      fcmd_q <= fcmd_d;
      fb2_q <= fb2_d;
      nb_q <= nb_d;
      hold_q <= hold_d;
      cmd_q <= cmd_d;
      grp_q <= grp_d;
      buf2_q <= buf2_d;
      cmd_start_q <= start_d;
      reject_q <= rej_d;
      sw_reset_q <= swr_d;
      busy_q <= (st_d == SFCS_S_B_BUSY || st_d == SFCS_S_D_BUSY);
      suspended_q <= (st_d == SFCS_S_B_SUSP);
      power_down_q <= pd_d;
    end
  end

endmodule

// ===== sfcs_pkg.sv
// sfcs_pkg: opcodes, command codes, groups and widths for the serial
// flash command scheduler.
// assumes: shared by the byte receiver, the scheduler, the checker and the bench.
package sfcs_pkg;

  // ==========================================================
  // widths and counts
  localparam int SFCS_BYTE_W = 8;
  localparam int SFCS_BIT_CNT_W = 3;
  localparam int SFCS_CNT_W = 3;
  localparam logic [2:0] SFCS_SEQ_LEN = 3'h4; // multi-byte sequence length
  localparam logic [2:0] SFCS_BIT_LAST = 3'h7; // last bit index in a byte
  localparam logic [2:0] SFCS_ZERO3 = 3'h0;

  // ==========================================================
  // single-byte opcodes
  localparam logic [7:0] OP_PAGE_RD = 8'hD2;
  localparam logic [7:0] OP_ARR_LP = 8'h01;
  localparam logic [7:0] OP_ARR_LF = 8'h03;
  localparam logic [7:0] OP_ARR_HF = 8'h0B;
  localparam logic [7:0] OP_ARR_HF2 = 8'h1B;
  localparam logic [7:0] OP_ARR_OLD = 8'hE8;
  localparam logic [7:0] OP_B1_RD_LF = 8'hD1;
  localparam logic [7:0] OP_B2_RD_LF = 8'hD3;
  localparam logic [7:0] OP_B1_RD_HF = 8'hD4;
  localparam logic [7:0] OP_B2_RD_HF = 8'hD6;
  localparam logic [7:0] OP_B1_WR = 8'h84;
  localparam logic [7:0] OP_B2_WR = 8'h87;
  localparam logic [7:0] OP_B1_PROG_E = 8'h83;
  localparam logic [7:0] OP_B2_PROG_E = 8'h86;
  localparam logic [7:0] OP_B1_PROG = 8'h88;
  localparam logic [7:0] OP_B2_PROG = 8'h89;
  localparam logic [7:0] OP_B1_THRU_E = 8'h82;
  localparam logic [7:0] OP_B2_THRU_E = 8'h85;
  localparam logic [7:0] OP_B1_THRU = 8'h02;
  localparam logic [7:0] OP_PAGE_ER = 8'h81;
  localparam logic [7:0] OP_BLOCK_ER = 8'h50;
  localparam logic [7:0] OP_SECT_ER = 8'h7C;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] OP_B1_RMW = 8'h58;
  localparam logic [7:0] OP_B2_RMW = 8'h59;
  localparam logic [7:0] OP_B1_XFER = 8'h53;
  localparam logic [7:0] OP_B2_XFER = 8'h55;
  localparam logic [7:0] OP_B1_CMP = 8'h60;
  localparam logic [7:0] OP_B2_CMP = 8'h61;
  localparam logic [7:0] OP_PROT_RD = 8'h32;
  localparam logic [7:0] OP_LOCK_RD = 8'h35;
  localparam logic [7:0] OP_SEC_RD = 8'h77;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_UDPD = 8'h79;
  localparam logic [7:0] OP_STATUS = 8'hD7;
  localparam logic [7:0] OP_ID = 8'h9F;
  // older aliases still honoured
  localparam logic [7:0] OP_OLD_B1_RD = 8'h54;
  localparam logic [7:0] OP_OLD_B2_RD = 8'h56;
  localparam logic [7:0] OP_OLD_PAGE = 8'h52;
  localparam logic [7:0] OP_OLD_ARR = 8'h68;
  localparam logic [7:0] OP_OLD_STAT = 8'h57;

  // ==========================================================
  // four-byte sequence bytes
  localparam logic [7:0] SQ_CHIP_0 = 8'hC7;
  localparam logic [7:0] SQ_CHIP_1 = 8'h94;
  localparam logic [7:0] SQ_CHIP_2 = 8'h80;
  localparam logic [7:0] SQ_CHIP_3 = 8'h9A;
  localparam logic [7:0] SQ_PROT_0 = 8'h3D;
  localparam logic [7:0] SQ_PROT_1 = 8'h2A;
  localparam logic [7:0] SQ_PROT_2 = 8'h7F;
  localparam logic [7:0] SQ_CFG_2 = 8'h80;
  localparam logic [7:0] SQ_P_EN = 8'hA9;
  localparam logic [7:0] SQ_P_DIS = 8'h9A;
  localparam logic [7:0] SQ_P_ERASE = 8'hCF;
  localparam logic [7:0] SQ_P_PROG = 8'hFC;
  localparam logic [7:0] SQ_P_LOCK = 8'h30;
  localparam logic [7:0] SQ_CFG_BIN = 8'hA6;
  localparam logic [7:0] SQ_CFG_STD = 8'hA7;
  localparam logic [7:0] SQ_FRZ_0 = 8'h34;
  localparam logic [7:0] SQ_FRZ_1 = 8'h55;
  localparam logic [7:0] SQ_FRZ_2 = 8'hAA;
  localparam logic [7:0] SQ_FRZ_3 = 8'h40;
  localparam logic [7:0] SQ_SEC_0 = 8'h9B;
  localparam logic [7:0] SQ_RST_0 = 8'hF0;
  localparam logic [7:0] SQ_ZERO = 8'h00;

  // ==========================================================
  // command codes seen by the core
  typedef enum logic [5:0] {
    SFCS_C_NONE, SFCS_C_SEQ,
    SFCS_C_PAGE_RD, SFCS_C_ARRAY_RD, SFCS_C_PROT_RD, SFCS_C_LOCK_RD,
    SFCS_C_SEC_RD, SFCS_C_BUF_RD,
    SFCS_C_BUF_WR, SFCS_C_STATUS, SFCS_C_ID,
    SFCS_C_PAGE_ER, SFCS_C_BLOCK_ER, SFCS_C_SECT_ER, SFCS_C_CHIP_ER,
    SFCS_C_XFER, SFCS_C_CMP, SFCS_C_BUF_PROG_E, SFCS_C_BUF_PROG,
    SFCS_C_THRU_E, SFCS_C_THRU, SFCS_C_RMW,
    SFCS_C_SUSPEND, SFCS_C_RESUME,
    SFCS_C_PROT_EN, SFCS_C_PROT_DIS, SFCS_C_PROT_ER, SFCS_C_PROT_PROG,
    SFCS_C_LOCKDOWN, SFCS_C_FREEZE, SFCS_C_SEC_PROG,
    SFCS_C_CFG_BIN, SFCS_C_CFG_STD,
    SFCS_C_SW_RESET, SFCS_C_DPD, SFCS_C_UDPD, SFCS_C_WAKE
  } sfcs_cmd_e;

  // command groups; misc covers power, suspend, resume and reset
  typedef enum logic [2:0] {
    SFCS_G_NONE, SFCS_G_A, SFCS_G_B, SFCS_G_C, SFCS_G_D, SFCS_G_MISC
  } sfcs_grp_e;

  // scheduler states
  typedef enum logic [1:0] {
    SFCS_S_IDLE, SFCS_S_B_BUSY, SFCS_S_B_SUSP, SFCS_S_D_BUSY
  } sfcs_state_e;

endpackage

// ===== sfcs_byte_rx.sv
// sfcs_byte_rx: serial byte receiver for the command scheduler.
// assumes: chip select, serial clock and data in arrive synchronous to
// clk and the serial clock is well below half the clk rate (modes 0/3).
`timescale 1ns/1ps
module sfcs_byte_rx
  import sfcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n, // chip select, active low
  input wire logic sclk, // serial clock from the host
  input wire logic si, // serial data in, msb first
  output logic [SFCS_BYTE_W-1:0] byte_q, // last complete byte
  output logic byte_stb_q, // one-cycle pulse per byte
  output logic frame_end_q, // one-cycle pulse on select release
  output logic aligned_q // release fell on a byte boundary
);

  // ==========================================================
  // state
  logic sclk_q; // previous serial clock level
  logic sclk_d;
  logic cs_n_q; // previous select level
  logic cs_n_d;
  logic [SFCS_BIT_CNT_W-1:0] bits_q; // bits taken in this byte
  logic [SFCS_BIT_CNT_W-1:0] bits_d;
  logic [SFCS_BYTE_W-1:0] shift_q; // byte under assembly
  logic [SFCS_BYTE_W-1:0] shift_d;
  logic [SFCS_BYTE_W-1:0] byte_d;
  logic byte_stb_d;
  logic frame_end_d;
  logic aligned_d;

  // next-state: sample on the rising serial clock edge
  always_comb begin
    sclk_d = sclk;
    cs_n_d = cs_n;
    bits_d = bits_q;
    shift_d = shift_q;
    byte_d = byte_q;
    byte_stb_d = 1'b0;
    frame_end_d = 1'b0;
    aligned_d = aligned_q;
    if (cs_n) begin
      // idle or released: restart the bit counter for the next frame
      bits_d = SFCS_ZERO3;
      if (!cs_n_q) begin
        frame_end_d = 1'b1;
        aligned_d = (bits_q == SFCS_ZERO3);
      end
    end else if (sclk && !sclk_q) begin
      shift_d = {shift_q[SFCS_BYTE_W-2:0], si};
      bits_d = bits_q + 3'h1;
      if (bits_q == SFCS_BIT_LAST) begin
        byte_d = {shift_q[SFCS_BYTE_W-2:0], si};
        byte_stb_d = 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      bits_q <= '0;
      shift_q <= '0;
      byte_q <= '0;
      byte_stb_q <= 1'b0;
      frame_end_q <= 1'b0;
      aligned_q <= 1'b0;
    end else begin
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      byte_q <= byte_d;
      byte_stb_q <= byte_stb_d;
      frame_end_q <= frame_end_d;
      aligned_q <= aligned_d;
    end
  end

endmodule

// ===== sfcs_host.sv
// sfcs_host: behavioural serial host that frames commands for the bench.
// assumes: the bench calls frame() and waits for it to return.
`timescale 1ns/1ps
module sfcs_host (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  // idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // ==========================================================
  // frame
  // whole frame before next
  task automatic frame(input logic [31:0] w, input int nbits);
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      si = w[i];
      repeat (2) @(negedge clk);
      sclk = 1'b1;
      repeat (2) @(negedge clk);
      sclk = 1'b0;
    end
    @(negedge clk);
    cs_n = 1'b1;
    // a released line must not look like a held bit
    si = ~si;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ===== sfcs_sched_chk.sv
// sfcs_sched_chk: admission and state checks on the scheduler ports.
// assumes: bound into every sfcs_sched, single clock domain.
`timescale 1ns/1ps
module sfcs_sched_chk
  import sfcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic op_done,
  input sfcs_cmd_e cmd_q,
  input sfcs_grp_e grp_q,
  input wire logic buf2_q,
  input wire logic cmd_start_q,
  input wire logic reject_q,
  input wire logic busy_q,
  input wire logic suspended_q,
  input wire logic power_down_q
);
  // ==========================================================
  // launcher of the self-timed phase; later starts overwrite cmd_q
  sfcs_cmd_e own_c_q, own_c_d;
  sfcs_grp_e own_g_q, own_g_d;
  logic own_b_q, own_b_d;
  always_comb begin
    own_c_d = own_c_q;
    own_g_d = own_g_q;
    own_b_d = own_b_q;
    if (cmd_start_q && (grp_q == SFCS_G_B || grp_q == SFCS_G_D)) begin
      own_c_d = cmd_q;
      own_g_d = grp_q;
      own_b_d = buf2_q;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      own_c_q <= SFCS_C_NONE;
      own_g_q <= SFCS_G_NONE;
      own_b_q <= 1'b0;
    end else begin
      own_c_q <= own_c_d;
      own_g_q <= own_g_d;
      own_b_q <= own_b_d;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_busy_susp_excl: assert property (!(busy_q && suspended_q))
    else $error("busy and suspended together");
  a_done_clears: assert property (busy_q && op_done |=> !busy_q)
    else $error("busy stays after op_done");
  a_d_status_only: assert property (cmd_start_q && $past(busy_q) &&
    own_g_q == SFCS_G_D |-> cmd_q == SFCS_C_STATUS)
    else $error("non-status start during D phase");
  a_b_concur: assert property (cmd_start_q && $past(busy_q) &&
    own_g_q == SFCS_G_B |-> grp_q inside {SFCS_G_C, SFCS_G_MISC})
    else $error("wrong group during B phase");
  a_other_buffer: assert property (cmd_start_q && $past(busy_q) &&
    cmd_q == SFCS_C_BUF_WR && own_g_q == SFCS_G_B &&
    !(own_c_q inside {SFCS_C_PAGE_ER, SFCS_C_BLOCK_ER, SFCS_C_SECT_ER,
    SFCS_C_CHIP_ER}) |-> buf2_q != own_b_q)
    else $error("buffer write hit busy buffer");
  a_susp_kind: assert property ($rose(suspended_q) |-> cmd_start_q &&
    !(own_c_q inside {SFCS_C_XFER, SFCS_C_CMP, SFCS_C_RMW}))
    else $error("suspend of unsuspendable op");
  a_pd_wake_only: assert property (cmd_start_q && $past(power_down_q)
    |-> cmd_q == SFCS_C_WAKE)
    else $error("start other than wake in power-down");
  a_reject_quiet: assert property (reject_q |-> $stable(busy_q) &&
    $stable(suspended_q) && $stable(power_down_q))
    else $error("refused command changed state");
endmodule
bind sfcs_sched sfcs_sched_chk sfcs_sched_chk_inst (.clk(clk),
  .reset_n(reset_n), .op_done(op_done), .cmd_q(cmd_q), .grp_q(grp_q),
  .buf2_q(buf2_q), .cmd_start_q(cmd_start_q), .reject_q(reject_q),
  .busy_q(busy_q), .suspended_q(suspended_q),
  .power_down_q(power_down_q));

// ===== tb_top.sv
// tb_top: self-checking bench for the command scheduler.
// assumes: sfcs_host frames commands, the bench plays the array engine.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("Error %s expected %0h seen %0h", n, e, g); n_errors++; end end
module tb_top
  import sfcs_pkg::*;
;
  logic clk, reset_n, op_done;
  wire cs_n, sclk, si;
  sfcs_cmd_e cmd_q, got_c;
  sfcs_grp_e grp_q, got_g;
  logic buf2_q, cmd_start_q, reject_q, sw_reset_q, busy_q, got_b;
  logic suspended_q, power_down_q;
  int n_errors = 0, compares = 0, n_s = 0, n_r = 0, n_w = 0;
  // opcode and expected command ordinal
  logic [15:0] ops [38] = '{16'hD202, 16'h5202, 16'h0103, 16'h0303,
    16'h0B03, 16'h1B03, 16'hE803, 16'h6803, 16'h3204, 16'h3505, 16'h7706,
    16'hD107, 16'hD307, 16'hD407, 16'hD607, 16'h5407, 16'h5607, 16'h8408,
    16'h8708, 16'hD709, 16'h5709, 16'h9F0A, 16'h810B, 16'h500C, 16'h7C0D,
    16'h530F, 16'h550F, 16'h6010, 16'h6110, 16'h8311, 16'h8611, 16'h8812,
    16'h8912, 16'h8213, 16'h8513, 16'h0214, 16'h5815, 16'h5915};
  logic [39:0] seqs [10] = '{40'hC794809A0E, 40'h3D2A7FA918,
    40'h3D2A7F9A19, 40'h3D2A7FCF1A, 40'h3D2A7FFC1B, 40'h3D2A7F301C,
    40'h3455AA401D, 40'h9B0000001E, 40'h3D2A80A61F, 40'h3D2A80A720};
  sfcs_host sfcs_host_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si));
  sfcs_sched sfcs_sched_inst (.clk(clk), .reset_n(reset_n), .cs_n(cs_n),
    .sclk(sclk), .si(si), .op_done(op_done), .cmd_q(cmd_q), .grp_q(grp_q),
    .buf2_q(buf2_q), .cmd_start_q(cmd_start_q), .reject_q(reject_q),
    .sw_reset_q(sw_reset_q), .busy_q(busy_q), .suspended_q(suspended_q),
    .power_down_q(power_down_q));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pulse monitor: settled values at the falling edge
  always @(negedge clk) begin
    if (cmd_start_q === 1'b1) begin
      n_s++;
      got_c = cmd_q;
      got_g = grp_q;
      got_b = buf2_q;
    end
    if (reject_q === 1'b1) n_r++;
    if (sw_reset_q === 1'b1) n_w++;
  end
  function automatic sfcs_grp_e grp_of(input int o);
    if (o >= 2 && o <= 7) return SFCS_G_A;
    if (o >= 8 && o <= 10) return SFCS_G_C;
    if (o >= 11 && o <= 21) return SFCS_G_B;
    if (o >= 24 && o <= 32) return SFCS_G_D;
    return SFCS_G_MISC;
  endfunction
  // one frame; ord 0 means a refusal is expected
  task automatic send(input logic [31:0] w, input int nb, input int ord);
    int s0;
    int r0;
    s0 = n_s;
    r0 = n_r;
    sfcs_host_inst.frame(w, nb);
    `CHK("start", ord != 0, n_s - s0 == 1)
    `CHK("reject", ord == 0, n_r - r0 == 1)
    if (ord != 0) begin
      `CHK("cmd_q", sfcs_cmd_e'(ord), got_c)
      `CHK("grp_q", grp_of(ord), got_g)
    end
  endtask
  task automatic done();
    op_done = 1'b1;
    @(negedge clk);
    op_done = 1'b0;
    @(negedge clk);
    `CHK("busy_q", 1'b0, busy_q)
  endtask
  task automatic t_decode();
    foreach (ops[i]) begin
      send({ops[i][15:8], 24'h0}, 32, ops[i][7:0]);
      if (busy_q === 1'b1) done();
    end
    foreach (seqs[i]) begin
      send(seqs[i][39:8], 32, seqs[i][7:0]);
      done();
    end
  endtask
  task automatic t_busy();
    send(32'h83000000, 32, 17);
    send(32'hD7000000, 32, 9);
    send(32'h9F000000, 32, 10);
    send(32'h87000000, 32, 8);
    `CHK("buf2_q", 1'b1, got_b)
    send(32'h84000000, 32, 0);
    send(32'hD2000000, 32, 0);
    send(32'hB0000000, 32, 22);
    `CHK("suspended_q", 1'b1, suspended_q)
    send(32'hD2000000, 32, 2);
    send(32'hD4000000, 32, 7);
    send(32'h77000000, 32, 6);
    send(32'hD0000000, 32, 23);
    done();
    send(32'h53000000, 32, 15);
    send(32'hB0000000, 32, 0);
    done();
    send(32'h81000000, 32, 11);
    send(32'h84000000, 32, 8);
    send(32'hF0000000, 32, 33);
    `CHK("busy_q", 1'b0, busy_q)
  endtask
  task automatic t_other();
    int w0;
    send(32'h3D2A7FFC, 32, 27);
    send(32'hD7000000, 32, 9);
    send(32'h9F000000, 32, 0);
    done();
    send(32'hB0000000, 32, 0);
    send(32'hB9000000, 32, 34);
    send(32'hD7000000, 32, 0);
    send(32'hAB000000, 32, 36);
    send(32'h79000000, 32, 35);
    `CHK("power_down_q", 1'b1, power_down_q)
    send(32'hAB000000, 32, 36);
    w0 = n_w;
    sfcs_host_inst.frame(32'hF0000000, 32);
    `CHK("sw_reset", 1'b1, n_w - w0 == 1)
    send(32'hFF000000, 32, 0);
    send(32'h81000000, 28, 0);
    send(32'h3D2A7F00, 24, 0);
    `CHK("busy_q", 1'b0, busy_q)
  endtask
  initial begin
    reset_n = 1'b0;
    op_done = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    t_decode();
    t_busy();
    t_other();
    finish_test();
  end
  // watchdog well past the expected run time
  initial begin
    #3000000;
    n_errors++;
    finish_test();
  end
  task automatic finish_test();
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule
